// File: rtl/iccr_pkg.sv
// iccr_pkg: constants and types for the channel configuration registers
// assumes an 8-bit address / 8-bit data register port from the serial engine
package iccr_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ICCR_OFF_CH2_SETUP    = 8'h24;
  localparam logic [7:0] ICCR_OFF_CH0_TRACK    = 8'h25;
  localparam logic [7:0] ICCR_OFF_CH3_SETUP    = 8'h26;
  localparam logic [7:0] ICCR_OFF_CH12_TRACK   = 8'h28;
  localparam logic [7:0] ICCR_OFF_CH3_TRACK    = 8'h2B;
  localparam logic [7:0] ICCR_OFF_RAW0_LOW     = 8'h59;
  localparam logic [7:0] ICCR_OFF_RAW0_MID     = 8'h5A;
  localparam logic [7:0] ICCR_OFF_RAW0_HIGH    = 8'h5B;

  // ==========================================================================
  // reset values
  localparam logic [7:0] ICCR_RST_SETUP        = 8'h04;
  localparam logic [7:0] ICCR_RST_CH0_TRACK    = 8'hDA;
  localparam logic [7:0] ICCR_RST_CH12_TRACK   = 8'h50;
  localparam logic [7:0] ICCR_RST_CH3_TRACK    = 8'h01;
  localparam logic [7:0] ICCR_RST_RAW          = 8'h00;

  // ==========================================================================
  // field positions
  localparam int ICCR_SETUP_LOSS_BIT  = 7;
  localparam int ICCR_SETUP_FREQ_LSB  = 5;
  localparam int ICCR_SETUP_CYC_LSB   = 0;
  localparam int ICCR_TRK0_LSB        = 1;
  localparam int ICCR_TRK1_LSB        = 4;
  localparam int ICCR_TRK2_LSB        = 6;
  localparam int ICCR_TRK3_LSB        = 0;

  // ==========================================================================
  // frequency band codes
  typedef enum logic [1:0] {
    ICCR_BAND_LOW  = 2'h0,
    ICCR_BAND_MID  = 2'h1,
    ICCR_BAND_HIGH = 2'h2,
    ICCR_BAND_RSVD = 2'h3
  } iccr_band_t;

  // per-channel sensor setup as seen by the analog front end
  typedef struct packed {
    logic       loss_range_sel;  // 1: high loss range
    iccr_band_t freq_band;       // oscillation band
    logic [4:0] cycle_count;     // sensor cycle count
  } iccr_setup_t;

  // register port request
  typedef struct packed {
    logic       wr;              // write strobe
    logic       rd;              // read strobe
    logic [7:0] addr;            // register offset
    logic [7:0] wdata;           // write data
  } iccr_req_t;

endpackage

// File: rtl/iccr_raw_store.sv
// iccr_raw_store: holds the 24-bit channel 0 raw measurement
// assumes the converter pulses load with a new sample
`timescale 1ns/1ps
module iccr_raw_store #(
  parameter int WIDTH = 24
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             load,      // new sample strobe
  input  wire logic [WIDTH-1:0] sample,    // new sample value
  input  wire logic [1:0]       sel,       // byte select 0..2
  output logic      [7:0]       byte_q     // registered selected byte
);

  // ==========================================================================
  // storage
  logic [WIDTH-1:0] value_q;  // latest raw measurement

  // capture sample
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      value_q <= '0;
    end else if (load) begin
      value_q <= sample;
    end
  end

  // registered byte read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      byte_q <= iccr_pkg::ICCR_RST_RAW;
    end else begin
      case (sel)
        2'h0:    byte_q <= value_q[7:0];
        2'h1:    byte_q <= value_q[15:8];
        2'h2:    byte_q <= value_q[23:16];
        default: byte_q <= 8'h00;
      endcase
    end
  end

endmodule

// File: rtl/iccr_regs.sv
// iccr_regs: channel 2/3 setup, tracking factors, channel 0 raw bytes
// assumes a serial engine presents byte reads/writes as one-cycle strobes
`timescale 1ns/1ps
module iccr_regs #(
  parameter int RAW_WIDTH = 24
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire iccr_pkg::iccr_req_t   req,
  output iccr_pkg::iccr_setup_t      ch2_setup_q,
  output iccr_pkg::iccr_setup_t      ch3_setup_q,
  output logic [1:0]                 ch0_track_factor_q,
  output logic [1:0]                 ch1_track_factor_q,
  output logic [1:0]                 ch2_track_factor_q,
  output logic [1:0]                 ch3_track_factor_q,
  input  wire logic                  raw_load,
  input  wire logic [RAW_WIDTH-1:0]  ch0_raw_measurement,
  output logic [7:0]                 rdata_q,
  output logic                       rvalid_q
);

  // ==========================================================================
  // register map and read timing
  //   24h  channel 2 setup    loss[7] band[6:5] cycles[4:0], reset 04h
  //   25h  channel 0 factor   reserved[7:3] factor[2:1] reserved[0], DAh
  //   26h  channel 3 setup    same layout as 24h, reset 04h
  //   28h  channel 2/1 factor ch2[7:6] ch1[5:4] reserved[3:0], reset 50h
  //   2Bh  channel 3 factor   reserved[7:2] factor[1:0], reset 01h
  //   59h  raw bits 7:0       read only, reset 00h
  //   5Ah  raw bits 15:8      read only, reset 00h
  //   5Bh  raw bits 23:16     read only, reset 00h
  // a read is taken on the edge that sees req.rd; rvalid_q is high for the
  // next cycle and rdata_q carries the byte from the edge after that on
  // reserved bits are plain storage, so a host that writes back what it
  // read leaves them untouched
  // band code 3 is stored as written; keeping it out is the host's job

  // ==========================================================================
  // register storage, one byte per writable offset
  logic [7:0] ch2_cfg_q;       // channel2_sensor_setup image
  logic [7:0] ch0_trk_q;       // channel0_tracking_factor image
  logic [7:0] ch3_cfg_q;       // channel3_sensor_setup image
  logic [7:0] ch12_trk_q;      // channel1_2_tracking_factors image
  logic [7:0] ch3_trk_q;       // channel3_tracking_factor image
  logic [7:0] raw_byte;        // registered raw byte from store
  logic       rd_raw_q;        // last read hit a raw byte
  logic [7:0] rd_reg_q;        // captured register read data

  // ==========================================================================
  // address decode
  // one compare per offset: the map is sparse, a range decode buys nothing
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // offset hits, shared by the write enables and the read mux
  wire logic hit_ch2   = hit(req.addr, iccr_pkg::ICCR_OFF_CH2_SETUP);
  wire logic hit_trk0  = hit(req.addr, iccr_pkg::ICCR_OFF_CH0_TRACK);
  wire logic hit_ch3   = hit(req.addr, iccr_pkg::ICCR_OFF_CH3_SETUP);
  wire logic hit_trk12 = hit(req.addr, iccr_pkg::ICCR_OFF_CH12_TRACK);
  wire logic hit_trk3  = hit(req.addr, iccr_pkg::ICCR_OFF_CH3_TRACK);

  // write enables; a strobe to any other offset changes nothing
  wire logic we_ch2   = req.wr && hit_ch2;
  wire logic we_trk0  = req.wr && hit_trk0;
  wire logic we_ch3   = req.wr && hit_ch3;
  wire logic we_trk12 = req.wr && hit_trk12;
  wire logic we_trk3  = req.wr && hit_trk3;

  // raw bytes are read only; writes there are ignored
  wire logic hit_raw0 = hit(req.addr, iccr_pkg::ICCR_OFF_RAW0_LOW);
  wire logic hit_raw1 = hit(req.addr, iccr_pkg::ICCR_OFF_RAW0_MID);
  wire logic hit_raw2 = hit(req.addr, iccr_pkg::ICCR_OFF_RAW0_HIGH);
  wire logic hit_raw  = hit_raw0 || hit_raw1 || hit_raw2;
  // byte select for the store; a non-raw offset parks it on byte 0
  wire logic [1:0] raw_sel = hit_raw1 ? 2'h1 : (hit_raw2 ? 2'h2 : 2'h0);

  // read mux for the writable registers; unmapped offsets read as 00h
  // a priority chain is safe because at most one hit is high
  wire logic [7:0] reg_mux = hit_ch2   ? ch2_cfg_q  :
                             hit_trk0  ? ch0_trk_q  :
                             hit_ch3   ? ch3_cfg_q  :
                             hit_trk12 ? ch12_trk_q :
                             hit_trk3  ? ch3_trk_q  :
                             8'h00;

  // field slices of the stored bytes, factors as plain binary 0..3
  wire logic [1:0] fac0 = ch0_trk_q[iccr_pkg::ICCR_TRK0_LSB +: 2];
  wire logic [1:0] fac1 = ch12_trk_q[iccr_pkg::ICCR_TRK1_LSB +: 2];
  wire logic [1:0] fac2 = ch12_trk_q[iccr_pkg::ICCR_TRK2_LSB +: 2];
  wire logic [1:0] fac3 = ch3_trk_q[iccr_pkg::ICCR_TRK3_LSB +: 2];

  // ==========================================================================
  // setup registers, all eight bits writable
  // each byte has its own enable, so back-to-back writes never collide
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // power-on setup bytes
      ch2_cfg_q <= iccr_pkg::ICCR_RST_SETUP;
      ch3_cfg_q <= iccr_pkg::ICCR_RST_SETUP;
    end else begin
      // channel 2 setup write
      if (we_ch2) begin
        ch2_cfg_q <= req.wdata;
      end
      // channel 3 setup write
      if (we_ch3) begin
        ch3_cfg_q <= req.wdata;
      end
    end
  end

  // tracking factor registers, reserved bits kept as read/write
  // the whole byte is stored so reserved fields read back as written
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // power-on factor bytes
      ch0_trk_q  <= iccr_pkg::ICCR_RST_CH0_TRACK;
      ch12_trk_q <= iccr_pkg::ICCR_RST_CH12_TRACK;
      ch3_trk_q  <= iccr_pkg::ICCR_RST_CH3_TRACK;
    end else begin
      // channel 0 factor byte
      if (we_trk0) begin
        ch0_trk_q <= req.wdata;
      end
      // channel 1/2 factor byte
      if (we_trk12) begin
        ch12_trk_q <= req.wdata;
      end
      // channel 3 factor byte
      if (we_trk3) begin
        ch3_trk_q <= req.wdata;
      end
    end
  end

  // ==========================================================================
  // field outputs to the front end and button algorithm
  // registered once more so every output comes straight from a flop; the
  // fields therefore follow a write one edge after the register does
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // reset images match the register reset bytes
      ch2_setup_q        <= iccr_pkg::iccr_setup_t'(iccr_pkg::ICCR_RST_SETUP);
      ch3_setup_q        <= iccr_pkg::iccr_setup_t'(iccr_pkg::ICCR_RST_SETUP);
      ch0_track_factor_q <= iccr_pkg::ICCR_RST_CH0_TRACK[2:1];
      ch1_track_factor_q <= iccr_pkg::ICCR_RST_CH12_TRACK[5:4];
      ch2_track_factor_q <= iccr_pkg::ICCR_RST_CH12_TRACK[7:6];
      ch3_track_factor_q <= iccr_pkg::ICCR_RST_CH3_TRACK[1:0];
    end else begin
      // layout matches the struct: loss, band, cycles
      ch2_setup_q <= iccr_pkg::iccr_setup_t'(ch2_cfg_q);
      ch3_setup_q <= iccr_pkg::iccr_setup_t'(ch3_cfg_q);
      // factors passed as unsigned binary 0..3
      ch0_track_factor_q <= fac0;
      ch1_track_factor_q <= fac1;
      ch2_track_factor_q <= fac2;
      ch3_track_factor_q <= fac3;
    end
  end

  // ==========================================================================
  // raw measurement bytes, registered inside the store
  // the store registers the selected byte, which lines up with the
  // capture stage below: both hold the state seen at the read's edge
  // a load during a read may tear the bytes; there is no snapshot lock
  iccr_raw_store #(
    .WIDTH (RAW_WIDTH)
  ) u_raw (
    .clock  (clock),
    .rst    (rst),
    .load   (raw_load),
    .sample (ch0_raw_measurement),
    .sel    (raw_sel),
    .byte_q (raw_byte)
  );

  // ==========================================================================
  // read path
  // capture stage: mux output taken every edge, the flags mark the edge
  // on which req.rd was seen and whether it hit a raw byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // idle: no read pending
      rd_reg_q <= 8'h00;
      rd_raw_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      rd_reg_q <= reg_mux;
      rd_raw_q <= req.rd && hit_raw;
      rvalid_q <= req.rd;
    end
  end

  // read data output, one cycle after capture
  // holds until the next read completes, so a slow host can still fetch it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // reads before the first access return 00h
      rdata_q <= 8'h00;
    end else if (rvalid_q) begin
      // raw offsets take the store byte, others the captured mux value
      rdata_q <= rd_raw_q ? raw_byte : rd_reg_q;
    end
  end

endmodule

// File: sim/iccr_regs_chk_sva.sv
// iccr_regs_chk: port properties of iccr_regs
// assumes binding into iccr_regs, one clock, rst async high
`timescale 1ns/1ps
module iccr_regs_chk #(
  parameter int RAW_WIDTH = 24
) (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire iccr_pkg::iccr_req_t   req,
  input wire iccr_pkg::iccr_setup_t ch2_setup_q,
  input wire iccr_pkg::iccr_setup_t ch3_setup_q,
  input wire logic [1:0]            ch0_track_factor_q,
  input wire logic [1:0]            ch1_track_factor_q,
  input wire logic [1:0]            ch2_track_factor_q,
  input wire logic [1:0]            ch3_track_factor_q,
  input wire logic                  raw_load,
  input wire logic [RAW_WIDTH-1:0]  ch0_raw_measurement,
  input wire logic [7:0]            rdata_q,
  input wire logic                  rvalid_q
);
  // ==========================================================
  // shadow of the last loaded sample
  logic [RAW_WIDTH-1:0] raw_sh_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      raw_sh_q <= '0;
    end else if (raw_load) begin
      raw_sh_q <= ch0_raw_measurement;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // write or quiet read of one offset
  sequence wa(logic [7:0] a);
    req.wr && req.addr == a;
  endsequence
  sequence rda(logic [7:0] a);
    req.rd && req.addr == a && !raw_load;
  endsequence
  // ==========================================================
  // field outputs follow writes two edges on
  AST_CH2_WR: assert property (wa(8'h24) |=> ##1
    ch2_setup_q == $past(req.wdata, 2)) else $error("ch2 setup bad");
  AST_CH3_WR: assert property (wa(8'h26) |=> ##1
    ch3_setup_q == $past(req.wdata, 2)) else $error("ch3 setup bad");
  AST_TRK0: assert property (wa(8'h25) |=> ##1
    ch0_track_factor_q == $past(req.wdata[2:1], 2)) else $error("f0 bad");
  AST_TRK12: assert property (wa(8'h28) |=> ##1
    {ch2_track_factor_q, ch1_track_factor_q} == $past(req.wdata[7:4], 2))
    else $error("f1 f2 bad");
  AST_TRK3: assert property (wa(8'h2B) |=> ##1
    ch3_track_factor_q == $past(req.wdata[1:0], 2)) else $error("f3 bad");
  AST_RST_VAL: assert property ($fell(rst) |->
    ch2_setup_q == 8'h04 && ch3_setup_q == 8'h04 &&
    {ch3_track_factor_q, ch2_track_factor_q,
    ch1_track_factor_q, ch0_track_factor_q} == 8'h55)
    else $error("reset values bad");
  // read strobe answered by a one-cycle capture flag
  AST_RD_VALID: assert property (rvalid_q == $past(req.rd))
    else $error("read flag bad");
  AST_RAW_LOW: assert property (rda(8'h59) ##1 !raw_load |=>
    rdata_q == raw_sh_q[7:0]) else $error("raw low byte bad");
  AST_RAW_HIGH: assert property (rda(8'h5B) ##1 !raw_load |=>
    rdata_q == raw_sh_q[23:16]) else $error("raw high byte bad");
  // main scenarios
  cover property (wa(8'h25));
  cover property (rda(8'h5B));
  cover property ($fell(rst));
endmodule

bind iccr_regs iccr_regs_chk #(.RAW_WIDTH(RAW_WIDTH)) u_chk (
  .clock(clock), .rst(rst), .req(req), .ch2_setup_q(ch2_setup_q),
  .ch3_setup_q(ch3_setup_q), .ch0_track_factor_q(ch0_track_factor_q),
  .ch1_track_factor_q(ch1_track_factor_q),
  .ch2_track_factor_q(ch2_track_factor_q),
  .ch3_track_factor_q(ch3_track_factor_q), .raw_load(raw_load),
  .ch0_raw_measurement(ch0_raw_measurement), .rdata_q(rdata_q),
  .rvalid_q(rvalid_q));

// File: sim/iccr_host_model.sv
// iccr_host_model: host side of the byte register port
// assumes tasks are called from one process at a time
`timescale 1ns/1ps
module iccr_host_model (
  input  wire logic          clock,
  output iccr_pkg::iccr_req_t req,
  input  wire logic [7:0]    rdata_q,
  input  wire logic          rvalid_q
);
  // ==========================================================
  // one-cycle strobe per access
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, dw);
    @(posedge clock);
    req <= '{wr: w, rd: !w, addr: a, wdata: dw};
    @(posedge clock);
    req <= '0;
  endtask
  // full byte; caller passes reserved bits as read back
  task automatic wr(input logic [7:0] a, dw);
    xfer(1'b1, a, dw);
  endtask
  // wait for capture flag, take byte one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] dr,
                    output logic ok);
    ok = 1'b0;
    xfer(1'b0, a, 8'h00);
    for (int i = 0; i < 3 && ok !== 1'b1; i++) begin
      @(negedge clock);
      ok = rvalid_q;
    end
    @(negedge clock);
    dr = rdata_q;
  endtask
endmodule

// File: sim/test_inductive_channel_config_regs.sv
// test_inductive_channel_config_regs: register tests for iccr_regs
// assumes iccr_host_model on the port and the bound checker
`timescale 1ns/1ps
module test_inductive_channel_config_regs;
  logic                  clock    = 1'b0;
  logic                  rst      = 1'b1;
  logic                  raw_load = 1'b0;
  logic [23:0]           raw      = 24'h000000;
  iccr_pkg::iccr_req_t   req;
  iccr_pkg::iccr_setup_t s2, s3;
  logic [1:0]            f0, f1, f2, f3, fl;
  logic [7:0]            rdata_q, d, x;
  logic                  rvalid_q, ok;
  int                    miscompares = 0;
  int                    checked     = 0;
  localparam logic [7:0] RA [8] = '{8'h24, 8'h25, 8'h26, 8'h28,
                                    8'h2B, 8'h59, 8'h5A, 8'h5B};
  localparam logic [7:0] RV [8] = '{8'h04, 8'hDA, 8'h04, 8'h50,
                                    8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] SV [3] = '{8'h1F, 8'hA0, 8'h40};
  iccr_regs u_dut (.clock(clock), .rst(rst), .req(req),
    .ch2_setup_q(s2), .ch3_setup_q(s3), .ch0_track_factor_q(f0),
    .ch1_track_factor_q(f1), .ch2_track_factor_q(f2),
    .ch3_track_factor_q(f3), .raw_load(raw_load),
    .ch0_raw_measurement(raw), .rdata_q(rdata_q), .rvalid_q(rvalid_q));
  iccr_host_model u_host (.clock(clock), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q));
  // ==========================================================
  // clock, verdict, compares
  initial forever #25 clock = ~clock;
  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, e);
    u_host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error rvalid expected 1 seen %b", ok);
      test_done();
    end
    chk($sformatf("reg %h", a), e, d);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rchk(RA[i], RV[i]);
    end
    chk("factors", 8'h55, {f3, f2, f1, f0});
    for (int i = 0; i < 3; i++) begin
      x = ~SV[i] & 8'hBF;
      u_host.wr(8'h24, SV[i]);
      u_host.wr(8'h26, x);
      rchk(8'h24, SV[i]);
      rchk(8'h26, x);
      chk("ch2 setup", SV[i], s2);
      chk("ch3 setup", x, s3);
    end
    for (int f = 0; f < 4; f++) begin
      fl = 2'(f);
      u_host.wr(8'h25, {5'h1B, fl, 1'b0});
      u_host.wr(8'h28, {fl, ~fl, 4'h0});
      u_host.wr(8'h2B, {6'h00, ~fl});
      rchk(8'h25, {5'h1B, fl, 1'b0});
      rchk(8'h28, {fl, ~fl, 4'h0});
      rchk(8'h2B, {6'h00, ~fl});
      chk("factors", {~fl, fl, ~fl, fl}, {f3, f2, f1, f0});
    end
    @(posedge clock);
    raw <= 24'h123456;
    raw_load <= 1'b1;
    @(posedge clock);
    raw_load <= 1'b0;
    u_host.wr(8'h59, 8'hFF);
    rchk(8'h59, 8'h56);
    rchk(8'h5A, 8'h34);
    rchk(8'h5B, 8'h12);
    u_host.wr(8'h27, 8'hFF);
    rchk(8'h27, 8'h00);
    test_done();
  end
endmodule
